// [spcb_slave_port.sv]
// Mailbox slave port between an external master and the local processor,
// plus the cold-boot loader that fills memory from a byte stream.
// Assumes master strobes are synchronous to clock_i; serial bytes arrive
// already deserialised from serial port A.
// Notes on behaviour
// - Three byte mailboxes each direction, six in all.
// - Each of the three data addresses holds separate storage per direction; reads see the other side.
// - Master write strobe captures bus data into its write register.
// - Master write to status changes nothing; only signals.
// - Master read enable makes the port drive the selected register.
// - Local write of register zero raises the master interrupt line.
// - Master write of register zero interrupts the local processor if enabled.
// - Registers one and two never raise an interrupt.
// - Full flag set by any writer write, cleared by opposite read.
// - Status shows pending register-zero requests from each side.
// - Status readable from master and local processor.
// - Both boot pins low: run from address zero on select zero.
// - Other modes boot from serial async 2400, serial sync, or slave port.
// - Boot stream is address/address/data triplets, one store each.
// - Address top bit picks I/O space, else memory; 32K each.
// - An I/O store ends boot and starts execution at zero.
`timescale 1ns/10ps
module spcb_slave_port
    import spcb_pkg::*;
#(
    parameter int BAUD_DIV = SPCB_BAUD_DIV_CYC
) (
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    input  wire spcb_req_s     mstr_req_i,
    output logic [7:0]         mstr_data_o,
    output logic               mstr_data_oe_n_o,
    output logic               mstr_irq_o,
    output logic               mstr_status_sig_o,
    input  wire spcb_req_s     cpu_req_i,
    input  wire logic          cpu_irq_en_i,
    output logic [7:0]         cpu_rdata_o,
    output logic               cpu_irq_o,
    input  wire logic          boot_mode_pin_low_i,
    input  wire logic          boot_mode_pin_high_i,
    input  wire logic          ser_valid_i,
    input  wire logic [7:0]    ser_data_i,
    output logic               ser_ready_o,
    output logic               ser_async_o,
    output logic               ser_sync_o,
    output logic               ser_baud_tick_o,
    output logic               boot_wr_o,
    output spcb_boot_wr_s      boot_wr_data_o,
    output logic               run_o,
    output logic               exec_start_o,
    output logic               memory_select_zero_n_o,
    output logic               memory_output_enable_zero_n_o
);

    typedef enum logic [2:0] {
        ST_CAPTURE, ST_ADDR_HI, ST_ADDR_LO, ST_DATA, ST_WRITE, ST_RUN
    } spcb_state_e;

    // Pick one mailbox byte or the status word
    function automatic logic [7:0] reg_mux(input logic [1:0] sel,
                                           input logic [2:0][7:0] regs,
                                           input logic [7:0] status);
        logic [7:0] val;
        val = status;
        if (sel != SPCB_REG_STATUS) begin
            val = regs[sel];
        end
        return val;
    endfunction

    // Mailbox state, three bytes each way
    logic [2:0][7:0] m2s_reg, m2s_next;
    logic [2:0][7:0] s2m_reg, s2m_next;
    logic [2:0]      m2s_full_reg, m2s_full_next;
    logic [2:0]      s2m_full_reg, s2m_full_next;
    logic            pend_m2s_reg, pend_m2s_next;
    logic            pend_s2m_reg, pend_s2m_next;
    logic            cpu_irq_reg, cpu_irq_next;
    logic            sig_reg, sig_next;
    logic            mrd_prev_reg;
    logic [7:0]      status;
    logic            m_rd_evt, m_wr_data, c_wr_data;
    logic            loader_pop;

    // Pin output state
    logic [7:0]      mdata_reg, mdata_next;
    logic            moe_n_reg, moe_n_next;
    logic [7:0]      crdata_reg, crdata_next;

    // Loader state
    spcb_state_e                 state_reg, state_next;
    logic [1:0]                  mode_reg, mode_next;
    logic [7:0]                  ahi_reg, ahi_next;
    logic [7:0]                  alo_reg, alo_next;
    logic [7:0]                  bdat_reg, bdat_next;
    logic                        bwr_reg, bwr_next;
    spcb_boot_wr_s               bwd_reg, bwd_next;
    logic                        exec_reg, exec_next;
    logic                        sready_reg, sready_next;
    logic [SPCB_BAUD_CNT_W-1:0]  baud_cnt_reg, baud_cnt_next;
    logic                        tick_reg, tick_next;
    logic                        booting;

    // Boot FIFO wiring
    logic                        f_in_valid, f_in_ready;
    logic [7:0]                  f_in_data;
    logic                        f_out_valid, f_out_ready;
    logic [7:0]                  f_out_data;
    logic [SPCB_FIFO_CNT_W-1:0]  f_count;

    // Status word seen by both sides
    always_comb begin
        status = '0;
        status[SPCB_ST_M2S_FULL_LSB +: SPCB_NUM_DATA] = m2s_full_reg;
        status[SPCB_ST_S2M_FULL_LSB +: SPCB_NUM_DATA] = s2m_full_reg;
        status[SPCB_ST_M2S_PEND] = pend_m2s_reg;
        status[SPCB_ST_S2M_PEND] = pend_s2m_reg;
    end

    // Access events; the read enable counts once at its leading edge
    assign m_rd_evt  = mstr_req_i.rd & ~mrd_prev_reg;
    assign m_wr_data = mstr_req_i.wr & (mstr_req_i.addr != SPCB_REG_STATUS);
    assign c_wr_data = cpu_req_i.wr & (cpu_req_i.addr != SPCB_REG_STATUS);

    // Mailbox next values; clears first so a same-cycle write wins
    always_comb begin
        m2s_next      = m2s_reg;
        s2m_next      = s2m_reg;
        m2s_full_next = m2s_full_reg;
        s2m_full_next = s2m_full_reg;
        pend_m2s_next = pend_m2s_reg;
        pend_s2m_next = pend_s2m_reg;
        // Opposite-side reads empty a register
        if (m_rd_evt && mstr_req_i.addr != SPCB_REG_STATUS) begin
            s2m_full_next[mstr_req_i.addr] = 1'b0;
            if (mstr_req_i.addr == SPCB_REG_ZERO) begin
                pend_s2m_next = 1'b0;
            end
        end
        if (cpu_req_i.rd && cpu_req_i.addr != SPCB_REG_STATUS) begin
            m2s_full_next[cpu_req_i.addr] = 1'b0;
            if (cpu_req_i.addr == SPCB_REG_ZERO) begin
                pend_m2s_next = 1'b0;
            end
        end
        if (loader_pop) begin
            m2s_full_next[SPCB_REG_ZERO] = 1'b0;
            pend_m2s_next = 1'b0;
        end
        // Master writes land only in the master-to-slave set
        if (m_wr_data) begin
            m2s_next[mstr_req_i.addr]      = mstr_req_i.data;
            m2s_full_next[mstr_req_i.addr] = 1'b1;
            if (mstr_req_i.addr == SPCB_REG_ZERO) begin
                pend_m2s_next = 1'b1;  // Only register zero requests
            end
        end
        // Local writes land only in the slave-to-master set
        if (c_wr_data) begin
            s2m_next[cpu_req_i.addr]      = cpu_req_i.data;
            s2m_full_next[cpu_req_i.addr] = 1'b1;
            if (cpu_req_i.addr == SPCB_REG_ZERO) begin
                pend_s2m_next = 1'b1;
            end
        end
        cpu_irq_next = pend_m2s_next & cpu_irq_en_i;
        // Status writes store nothing, only pulse a signal
        sig_next = mstr_req_i.wr & (mstr_req_i.addr == SPCB_REG_STATUS);
    end

    // Mailbox registers, emptied at reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            m2s_reg      <= '0;
            s2m_reg      <= '0;
            m2s_full_reg <= '0;
            s2m_full_reg <= '0;
            pend_m2s_reg <= 1'b0;
            pend_s2m_reg <= 1'b0;
            cpu_irq_reg  <= 1'b0;
            sig_reg      <= 1'b0;
            mrd_prev_reg <= 1'b0;
        end else begin
            m2s_reg      <= m2s_next;
            s2m_reg      <= s2m_next;
            m2s_full_reg <= m2s_full_next;
            s2m_full_reg <= s2m_full_next;
            pend_m2s_reg <= pend_m2s_next;
            pend_s2m_reg <= pend_s2m_next;
            cpu_irq_reg  <= cpu_irq_next;
            sig_reg      <= sig_next;
            mrd_prev_reg <= mstr_req_i.rd;
        end
    end

    // Read data for both sides; the master pin is driven while reading
    always_comb begin
        mdata_next  = reg_mux(mstr_req_i.addr, s2m_reg, status);
        moe_n_next  = ~mstr_req_i.rd;
        crdata_next = crdata_reg;
        if (cpu_req_i.rd) begin
            crdata_next = reg_mux(cpu_req_i.addr, m2s_reg, status);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdata_reg  <= '0;
            moe_n_reg  <= 1'b1;
            crdata_reg <= '0;
        end else begin
            mdata_reg  <= mdata_next;
            moe_n_reg  <= moe_n_next;
            crdata_reg <= crdata_next;
        end
    end

    // Boot source select; slave-port bytes leave register zero as they are taken
    assign booting     = (state_reg != ST_RUN) && (state_reg != ST_CAPTURE);
    assign f_in_valid  = booting && ((mode_reg == SPCB_BOOT_SLAVE) ? m2s_full_reg[0]
                                                 : (ser_valid_i & sready_reg));
    assign f_in_data   = (mode_reg == SPCB_BOOT_SLAVE) ? m2s_reg[0] : ser_data_i;
    assign loader_pop  = f_in_valid & f_in_ready & (mode_reg == SPCB_BOOT_SLAVE);
    assign f_out_ready = (state_reg == ST_ADDR_HI) || (state_reg == ST_ADDR_LO)
                         || (state_reg == ST_DATA);

    spcb_fifo #(
        .WIDTH (SPCB_FIFO_WIDTH),
        .DEPTH (SPCB_FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (f_in_valid),
        .in_ready_o  (f_in_ready),
        .in_data_i   (f_in_data),
        .out_valid_o (f_out_valid),
        .out_ready_i (f_out_ready),
        .out_data_o  (f_out_data),
        .count_o     (f_count)
    );

    // Loader sequence: capture pins, take triplets, store, run
    always_comb begin
        state_next = state_reg;
        mode_next  = mode_reg;
        ahi_next   = ahi_reg;
        alo_next   = alo_reg;
        bdat_next  = bdat_reg;
        bwr_next   = 1'b0;
        bwd_next   = bwd_reg;
        exec_next  = 1'b0;
        case (state_reg)
            ST_CAPTURE: begin
                mode_next = {boot_mode_pin_high_i, boot_mode_pin_low_i};
                if (mode_next == SPCB_BOOT_MEM) begin
                    state_next = ST_RUN;
                    exec_next  = 1'b1;
                end else begin
                    state_next = ST_ADDR_HI;
                end
            end
            ST_ADDR_HI: begin
                if (f_out_valid) begin
                    ahi_next   = f_out_data;
                    state_next = ST_ADDR_LO;
                end
            end
            ST_ADDR_LO: begin
                if (f_out_valid) begin
                    alo_next   = f_out_data;
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                if (f_out_valid) begin
                    bdat_next  = f_out_data;
                    state_next = ST_WRITE;
                end
            end
            ST_WRITE: begin
                // Top bit picks the space, leaving 15 address bits
                bwd_next.io   = ahi_reg[7];
                bwd_next.addr = {ahi_reg[6:0], alo_reg};
                bwd_next.data = bdat_reg;
                bwr_next      = 1'b1;
                if (ahi_reg[7]) begin
                    state_next = ST_RUN;
                    exec_next  = 1'b1;
                end else begin
                    state_next = ST_ADDR_HI;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_CAPTURE;
            end
        endcase
    end

    // Serial side: ready with headroom for one late byte, and the baud enable
    always_comb begin
        sready_next   = booting && (mode_reg != SPCB_BOOT_SLAVE)
                        && (f_count <= SPCB_FIFO_SAFE_LVL);
        baud_cnt_next = '0;
        tick_next     = 1'b0;
        if (booting && mode_reg == SPCB_BOOT_SER_ASYNC) begin
            if (baud_cnt_reg == SPCB_BAUD_CNT_W'(BAUD_DIV - 1)) begin
                tick_next = 1'b1;
            end else begin
                baud_cnt_next = baud_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg    <= ST_CAPTURE;
            mode_reg     <= SPCB_BOOT_MEM;
            ahi_reg      <= '0;
            alo_reg      <= '0;
            bdat_reg     <= '0;
            bwr_reg      <= 1'b0;
            bwd_reg      <= '0;
            exec_reg     <= 1'b0;
            sready_reg   <= 1'b0;
            baud_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            mode_reg     <= mode_next;
            ahi_reg      <= ahi_next;
            alo_reg      <= alo_next;
            bdat_reg     <= bdat_next;
            bwr_reg      <= bwr_next;
            bwd_reg      <= bwd_next;
            exec_reg     <= exec_next;
            sready_reg   <= sready_next;
            baud_cnt_reg <= baud_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    // Outputs from flip-flops; run, select, enable and serial mode outputs decoded from state and mode flip-flops
    assign mstr_data_o                   = mdata_reg;
    assign mstr_data_oe_n_o              = moe_n_reg;
    assign mstr_irq_o                    = pend_s2m_reg;
    assign mstr_status_sig_o             = sig_reg;
    assign cpu_rdata_o                   = crdata_reg;
    assign cpu_irq_o                     = cpu_irq_reg;
    assign ser_ready_o                   = sready_reg;
    assign ser_async_o                   = booting & (mode_reg == SPCB_BOOT_SER_ASYNC);
    assign ser_sync_o                    = booting & (mode_reg == SPCB_BOOT_SER_SYNC);
    assign ser_baud_tick_o               = tick_reg;
    assign boot_wr_o                     = bwr_reg;
    assign boot_wr_data_o                = bwd_reg;
    assign run_o                         = (state_reg == ST_RUN);
    assign exec_start_o                  = exec_reg;
    assign memory_select_zero_n_o        = ~(state_reg == ST_RUN);
    assign memory_output_enable_zero_n_o = ~(state_reg == ST_RUN);

    // Checks on the guarded behaviour
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    AST_M_CAPTURE: assert property (
        (mstr_req_i.wr && mstr_req_i.addr == SPCB_REG_ZERO) |=> m2s_reg[0] == $past(mstr_req_i.data))
        else $error("master write not captured");
    AST_STATUS_NOP: assert property (
        (mstr_req_i.wr && mstr_req_i.addr == SPCB_REG_STATUS && !cpu_req_i.wr && !cpu_req_i.rd
         && !m_rd_evt && !loader_pop) |=> $stable(status) && mstr_status_sig_o)
        else $error("status write changed status");
    AST_READ_OPPOSITE: assert property (
        (mstr_req_i.rd && mstr_req_i.addr == 2'h1) |=> mstr_data_o == $past(s2m_reg[1]) && !mstr_data_oe_n_o)
        else $error("master read wrong data");
    AST_MSTR_IRQ: assert property (
        (cpu_req_i.wr && cpu_req_i.addr == SPCB_REG_ZERO) |=> mstr_irq_o)
        else $error("master interrupt missing");
    AST_CPU_IRQ: assert property (
        (mstr_req_i.wr && mstr_req_i.addr == SPCB_REG_ZERO && cpu_irq_en_i) |=> cpu_irq_o)
        else $error("local interrupt missing");
    AST_NO_IRQ_12: assert property (
        (!pend_s2m_reg && cpu_req_i.wr && cpu_req_i.addr != SPCB_REG_ZERO) |=> !mstr_irq_o)
        else $error("register one or two interrupted");
    AST_FULL_CLR: assert property (
        (m_rd_evt && mstr_req_i.addr == 2'h2 && !cpu_req_i.wr) |=> !s2m_full_reg[2])
        else $error("full flag not cleared");
    AST_STATUS_CPU: assert property (
        (cpu_req_i.rd && cpu_req_i.addr == SPCB_REG_STATUS) |=> cpu_rdata_o == $past(status))
        else $error("status not readable locally");
    AST_MEM_BOOT: assert property (
        (state_reg == ST_CAPTURE && !boot_mode_pin_low_i && !boot_mode_pin_high_i)
        |=> exec_start_o && run_o && !memory_select_zero_n_o)
        else $error("memory boot did not start");
    AST_IO_ENDS: assert property (
        (state_reg == ST_WRITE && ahi_reg[7]) |=> boot_wr_o && boot_wr_data_o.io && exec_start_o ##1 run_o)
        else $error("io store did not end boot");

    COV_M2S_IRQ: cover property (mstr_req_i.wr && mstr_req_i.addr == SPCB_REG_ZERO ##2 cpu_irq_o);
    COV_S2M_READ: cover property (mstr_irq_o ##[1:20] m_rd_evt && mstr_req_i.addr == SPCB_REG_ZERO);
    COV_BOOT_MEM: cover property (boot_wr_o && !boot_wr_data_o.io);
    COV_BOOT_END: cover property (exec_start_o && mode_reg == SPCB_BOOT_SLAVE);

endmodule

// [spcb_pkg.sv]
// Shared constants and carrier types for the slave port with cold-boot loader.
// Assumes a single 100 MHz clock domain and bus inputs synchronous to it.
package spcb_pkg;

    // Clock and boot serial rate
    localparam int SPCB_CLK_HZ        = 100_000_000;
    localparam int SPCB_BOOT_BAUD_BPS = 2400;
    localparam int SPCB_BAUD_DIV_CYC  = SPCB_CLK_HZ / SPCB_BOOT_BAUD_BPS;
    localparam int SPCB_BAUD_CNT_W    = 16;

    // Register map seen by both sides
    localparam int         SPCB_NUM_DATA   = 3;
    localparam logic [1:0] SPCB_REG_ZERO   = 2'h0;
    localparam logic [1:0] SPCB_REG_STATUS = 2'h3;

    // Status word layout
    localparam int SPCB_ST_M2S_FULL_LSB = 0;
    localparam int SPCB_ST_S2M_FULL_LSB = 3;
    localparam int SPCB_ST_M2S_PEND     = 6;
    localparam int SPCB_ST_S2M_PEND     = 7;

    // Boot mode codes, {high pin, low pin}
    localparam logic [1:0] SPCB_BOOT_MEM       = 2'h0;
    localparam logic [1:0] SPCB_BOOT_SER_ASYNC = 2'h1;
    localparam logic [1:0] SPCB_BOOT_SER_SYNC  = 2'h2;
    localparam logic [1:0] SPCB_BOOT_SLAVE     = 2'h3;

    // Boot stream and buffer shape
    localparam int SPCB_ADDR_W     = 15;
    localparam int SPCB_FIFO_WIDTH = 8;
    localparam int SPCB_FIFO_DEPTH = 8;
    localparam int SPCB_FIFO_CNT_W = 4;
    localparam logic [SPCB_FIFO_CNT_W-1:0] SPCB_FIFO_SAFE_LVL = 4'h6;

    // One register access from either side
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] data;
    } spcb_req_s;

    // One boot store
    typedef struct packed {
        logic                   io;
        logic [SPCB_ADDR_W-1:0] addr;
        logic [7:0]             data;
    } spcb_boot_wr_s;

endpackage

// [spcb_fifo.sv]
// Byte FIFO with valid/ready on both sides for the boot stream.
// Assumes one clock; a push into a full FIFO is refused by in_ready_o.
`timescale 1ns/10ps
module spcb_fifo
    import spcb_pkg::*;
#(
    parameter int WIDTH = SPCB_FIFO_WIDTH,
    parameter int DEPTH = SPCB_FIFO_DEPTH
) (
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [WIDTH-1:0]                out_data_o,
    output logic [$clog2(DEPTH):0]          count_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_ptr_reg, wr_ptr_next;
    logic [PW:0]      rd_ptr_reg, rd_ptr_next;
    logic             push, pop;

    // Honest full and empty from the pointer difference
    assign count_o     = wr_ptr_reg - rd_ptr_reg;
    assign in_ready_o  = (count_o != (PW+1)'(DEPTH));
    assign out_valid_o = (count_o != '0);
    assign out_data_o  = mem[rd_ptr_reg[PW-1:0]];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Pointer advance
    always_comb begin
        wr_ptr_next = wr_ptr_reg + (PW+1)'(push);
        rd_ptr_next = rd_ptr_reg + (PW+1)'(pop);
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr_reg[PW-1:0]] <= in_data_i;
        end
    end

endmodule

// [spcb_master_model.sv]
// Master processor model that drives the slave port's master bus.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/10ps
module spcb_master_model
    import spcb_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic [7:0] data_i,
    input  wire logic       oe_n_i,
    output spcb_req_s       req_o
);
    initial req_o = '0;
    // One-cycle write strobe; the data lines then show the inverse value
    task automatic write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clock_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: a, data: ~d};
    endtask
    // Read enable held until the port drives, then dropped for a cycle
    task automatic read(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        repeat (2) @(posedge clock_i);
        d = (oe_n_i === 1'b0) ? data_i : 8'hXX;
        req_o.rd <= 1'b0;
        @(posedge clock_i);
    endtask
endmodule

// [tb.sv]
// Testbench for the slave port: mailboxes, status, interrupts, serial boot.
// Assumes the master model owns the master bus; bench drives the rest.
`timescale 1ns/10ps
module tb;
    import spcb_pkg::*;
    logic          clock_i, rst_n_i, irq_en, pin_lo, pin_hi, ser_valid;
    logic [7:0]    ser_data, mdata, cpu_rdata, d;
    logic          oe_n, mirq, msig, cirq, sready, sasync, bwr, run, xstart, msel_n;
    logic          ssync, tick, moe0_n;
    spcb_req_s     mreq, cpu_req_i;
    spcb_boot_wr_s bdata;
    int            n_fail, check_count;
    spcb_master_model spcb_master_model_inst (.clock_i(clock_i), .data_i(mdata),
        .oe_n_i(oe_n), .req_o(mreq));
    spcb_slave_port #(.BAUD_DIV(4)) spcb_slave_port_inst (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .mstr_req_i(mreq), .mstr_data_o(mdata),
        .mstr_data_oe_n_o(oe_n), .mstr_irq_o(mirq), .mstr_status_sig_o(msig),
        .cpu_req_i(cpu_req_i), .cpu_irq_en_i(irq_en), .cpu_rdata_o(cpu_rdata),
        .cpu_irq_o(cirq), .boot_mode_pin_low_i(pin_lo), .boot_mode_pin_high_i(pin_hi),
        .ser_valid_i(ser_valid), .ser_data_i(ser_data), .ser_ready_o(sready),
        .ser_async_o(sasync), .ser_sync_o(ssync), .ser_baud_tick_o(tick), .boot_wr_o(bwr),
        .boot_wr_data_o(bdata), .run_o(run), .exec_start_o(xstart),
        .memory_select_zero_n_o(msel_n), .memory_output_enable_zero_n_o(moe0_n));
    // 100 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Compare and count
    task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Local processor access, one cycle; read data settled on return
    task automatic cpu(input logic w, input logic [1:0] a, input logic [7:0] v);
        @(posedge clock_i);
        cpu_req_i <= '{wr: w, rd: ~w, addr: a, data: v};
        @(posedge clock_i);
        cpu_req_i <= '0;
        #1;
    endtask
    task automatic settle;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic do_reset(input logic [1:0] mode);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        {pin_hi, pin_lo} <= mode;
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
    endtask
    task automatic ser(input logic [7:0] b);
        ser_valid <= 1'b1;
        ser_data <= b;
        do @(posedge clock_i); while (sready !== 1'b1);
    endtask
    // Serial boot: one memory store, then an I/O store that ends boot
    task automatic t_boot;
        int n;
        do_reset(SPCB_BOOT_SER_ASYNC);
        settle();
        check("async mode", 24'h1, {23'h0, sasync});
        check("not running", 24'h0, {23'h0, run});
        n = 0;
        repeat (8) begin
            @(posedge clock_i);
            if (tick === 1'b1) n++;
        end
        check("baud ticks", 24'h2, n[23:0]);
        @(posedge clock_i);
        ser(8'h00);
        ser(8'h10);
        ser(8'h5A);
        ser_valid <= 1'b0;
        for (int i = 0; i < 30 && bwr !== 1'b1; i++) @(posedge clock_i);
        check("memory store", {1'b0, 15'h0010, 8'h5A}, bdata);
        check("no start", 24'h0, {23'h0, xstart});
        ser(8'h80);
        ser(8'h02);
        ser(8'h3C);
        ser_valid <= 1'b0;
        for (int i = 0; i < 30 && bwr !== 1'b1; i++) @(posedge clock_i);
        check("io store", {1'b1, 15'h0002, 8'h3C}, bdata);
        check("start", 24'h1, {23'h0, xstart});
        @(posedge clock_i);
        #1;
        check("running", 24'h4, {21'h0, run, msel_n, moe0_n});
        $display("boot test done");
    endtask
    task automatic t_reset;
        do_reset(SPCB_BOOT_MEM);
        cpu(1'b0, 2'h3, 8'h00);
        check("reset status", 24'h0, {16'h0, cpu_rdata});
        check("mem boot", 24'h2, {22'h0, run, msel_n});
        $display("reset test done");
    endtask
    task automatic t_m2s;
        spcb_master_model_inst.write(2'h1, 8'hA1);
        spcb_master_model_inst.write(2'h2, 8'hA2);
        spcb_master_model_inst.write(2'h0, 8'hA0);
        cpu(1'b0, 2'h3, 8'h00);
        check("m2s status", 24'h47, {16'h0, cpu_rdata});
        check("cpu irq", 24'h1, {23'h0, cirq});
        spcb_master_model_inst.read(2'h1, d);
        check("own write hidden", 24'h0, {16'h0, d});
        cpu(1'b0, 2'h1, 8'h00);
        check("m2s reg1", 24'hA1, {16'h0, cpu_rdata});
        cpu(1'b0, 2'h0, 8'h00);
        check("m2s reg0", 24'hA0, {16'h0, cpu_rdata});
        cpu(1'b0, 2'h3, 8'h00);
        check("after reads", 24'h04, {16'h0, cpu_rdata});
        $display("master to slave test done");
    endtask
    task automatic t_s2m;
        cpu(1'b1, 2'h1, 8'hB1);
        settle();
        check("reg1 no irq", 24'h0, {23'h0, mirq});
        cpu(1'b1, 2'h0, 8'hB0);
        settle();
        check("master irq", 24'h1, {23'h0, mirq});
        spcb_master_model_inst.read(2'h3, d);
        check("s2m status", 24'h9C, {16'h0, d});
        spcb_master_model_inst.read(2'h0, d);
        check("s2m reg0", 24'hB0, {15'h0, mirq, d});
        $display("slave to master test done");
    endtask
    task automatic t_status;
        @(posedge clock_i);
        irq_en <= 1'b0;
        spcb_master_model_inst.write(2'h3, 8'hFF);
        #1;
        check("status signal", 24'h1, {23'h0, msig});
        cpu(1'b0, 2'h3, 8'h00);
        check("status kept", 24'h14, {16'h0, cpu_rdata});
        spcb_master_model_inst.write(2'h0, 8'h55);
        settle();
        check("irq disabled", 24'h0, {23'h0, cirq});
        $display("status signal test done");
    endtask
    // Sync mode, then boot over the slave port ending in one I/O store
    task automatic t_slave_boot;
        do_reset(SPCB_BOOT_SER_SYNC);
        settle();
        check("sync mode", 24'h2, {22'h0, ssync, sasync});
        do_reset(SPCB_BOOT_SLAVE);
        settle();
        spcb_master_model_inst.write(2'h0, 8'h81);
        spcb_master_model_inst.write(2'h0, 8'h07);
        spcb_master_model_inst.write(2'h0, 8'hC3);
        for (int i = 0; i < 30 && bwr !== 1'b1; i++) @(posedge clock_i);
        check("slave boot", {1'b1, 15'h0107, 8'hC3}, bdata);
        $display("slave boot test done");
    endtask
    initial begin
        rst_n_i = 1'b0;
        cpu_req_i = '0;
        irq_en = 1'b1;
        {pin_hi, pin_lo} = 2'b00;
        ser_valid = 1'b0;
        ser_data = 8'h00;
        t_reset();
        t_m2s();
        t_s2m();
        t_status();
        t_boot();
        t_slave_boot();
        finish_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #50000;
        n_fail++;
        finish_test();
    end
endmodule
